// ===== swcs_pkg.sv
// Package for switchgear command supervision: constants and carrier types
package swcs_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] SWCS_CTRL_OFS = 8'h00;
  localparam logic [7:0] SWCS_STAT_OFS = 8'h04;
  localparam logic [7:0] SWCS_FLAG_OFS = 8'h08;
  localparam logic [7:0] SWCS_TDIS_OFS = 8'h0c;
  localparam logic [7:0] SWCS_TSYN_OFS = 8'h10;
  localparam logic [7:0] SWCS_TRUN_OFS = 8'h14;
  localparam logic [7:0] SWCS_TSLW_OFS = 8'h18;

  // Control register field positions
  localparam int SWCS_CTRL_SINGLE_BIT = 0;
  localparam int SWCS_CTRL_INCL_ON_BIT = 1;
  localparam int SWCS_CTRL_INCL_OFF_BIT = 2;
  localparam int SWCS_CTRL_SYNC_BIT = 3;

  // Reset values
  localparam logic [3:0] SWCS_CTRL_RST = 4'h6;
  localparam logic [15:0] SWCS_TDIS_RST = 16'h00fa;
  localparam logic [15:0] SWCS_TSYN_RST = 16'h01f4;
  localparam logic [15:0] SWCS_TRUN_RST = 16'h07d0;
  localparam logic [15:0] SWCS_TSLW_RST = 16'h03e8;

  // Time base: one supervision tick is 1 ms at 25 MHz
  localparam int SWCS_CLK_HZ = 25000000;
  localparam int SWCS_TICK_US = 1000;
  localparam int SWCS_TICK_CYC = SWCS_CLK_HZ / 1000000 * SWCS_TICK_US;

  // Supervision flag indices
  localparam int SWCS_NFLAG = 10;
  localparam int SWCS_F_OK = 0;
  localparam int SWCS_F_DIST = 1;
  localparam int SWCS_F_TRIP = 2;
  localparam int SWCS_F_DIR = 3;
  localparam int SWCS_F_ONOFF = 4;
  localparam int SWCS_F_NRDY = 5;
  localparam int SWCS_F_LOCK = 6;
  localparam int SWCS_F_SYNC = 7;
  localparam int SWCS_F_WDRN = 8;
  localparam int SWCS_F_RUN = 9;

  // Decoded breaker position
  typedef struct packed {
    logic closed;
    logic open;
    logic indeterm;
    logic contra;
  } swcs_pos_t;

  // Breaker-side inputs
  typedef struct packed {
    logic aux_on;
    logic aux_off;
    logic ready;
    logic removed;
    logic in_sync;
  } swcs_brk_t;

endpackage

// ===== swcs_switchgear_unit.sv
// Switchgear position evaluation and switching command supervision
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Indeterminate output high while position resolves to neither open nor closed. The code drops it once contradicting contacts raise disturbed.
// RULE_02: Contradicting contacts start a timer; disturbed goes high when it expires.
// RULE_03: Ready output follows breaker ready input.
// RULE_04: Removed output high while breaker reported withdrawn.
// RULE_05: Close-interlock indication is OR of all close-interlock inputs.
// RULE_06: Open-interlock indication is OR of all open-interlock inputs.
// RULE_07: Success flag when commanded position is reached.
// RULE_08: Failed-disturbed flag when command ends in disturbed position.
// RULE_09: Refuse command while protection trip pending; flag trip as cause.
// RULE_10: Direction flag for open when open or close when closed.
// RULE_11: Flag close command received while open command pending.
// RULE_12: Not-ready flag when command attempted while breaker not ready.
// RULE_13: Withhold interlocked command and raise field-lock flag.
// RULE_14: Sync close runs timer; no in-sync before expiry drops command, flags.
// RULE_15: Withdrawn flag when command fails because breaker removed.
// RULE_16: Setting includes or excludes protection close and trip in outputs.
// RULE_17: Slow-breaker alarm on degraded operating time; cleared only by request.
// RULE_18: Breaker supplies normally-open contact as closed check-back.
// RULE_19: Breaker supplies normally-closed contact as open check-back.
// RULE_20: Synchroniser asserts in-sync within sync time after request.
// RULE_21: Single-contact configuration suppresses indeterminate and disturbed flags.
// RULE_22: Decode: 10 closed, 01 open, 00 indeterminate, 11 contradictory.
// RULE_23: Flags latch until next accepted command; one cause per command. The code also replaces them with the cause of a refused command.
module swcs_switchgear_unit
  import swcs_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Breaker pins
  input wire swcs_brk_t i_brk,
  input wire logic [2:0] i_close_lock_input,
  input wire logic [2:0] i_open_lock_input,
  // Command sources
  input wire logic i_cmd_on,
  input wire logic i_cmd_off,
  input wire logic i_prot_on,
  input wire logic i_protection_open_request,
  input wire logic i_trip_acknowledge,
  input wire logic i_slow_breaker_alarm_clear,
  // Breaker commands
  output logic o_on_cmd,
  output logic o_off_cmd,
  output logic o_sync_on_request,
  // Status
  output logic o_pos_on,
  output logic o_pos_off,
  output logic o_pos_indeterm,
  output logic o_pos_disturb,
  output logic o_ready,
  output logic o_removed,
  output logic o_close_lock,
  output logic o_open_lock,
  output logic o_trip_pending,
  output logic o_slow_breaker_alarm,
  output logic [SWCS_NFLAG-1:0] o_flags
);

  typedef enum logic [1:0] {SWCS_IDLE, SWCS_SYNC, SWCS_RUN} swcs_state_t;

  // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  logic [4:0] sync1_r, sync2_r, sync3_r, brk_r;
  logic [2:0] cl1_r, cl2_r, cl3_r, cl_r;
  logic [2:0] ol1_r, ol2_r, ol3_r, ol_r;
  logic [4:0] brk_pins;
  assign brk_pins = i_brk;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_r <= '0; sync2_r <= '0; sync3_r <= '0; brk_r <= '0;
      cl1_r <= '0; cl2_r <= '0; cl3_r <= '0; cl_r <= '0;
      ol1_r <= '0; ol2_r <= '0; ol3_r <= '0; ol_r <= '0;
    end else if (i_ce) begin
      sync1_r <= brk_pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      cl1_r <= i_close_lock_input;
      cl2_r <= cl1_r;
      cl3_r <= cl2_r;
      ol1_r <= i_open_lock_input;
      ol2_r <= ol1_r;
      ol3_r <= ol2_r;
      for (int k = 0; k < 5; k++) begin
        if (sync2_r[k] == sync3_r[k]) brk_r[k] <= sync3_r[k];
      end
      for (int k = 0; k < 3; k++) begin
        if (cl2_r[k] == cl3_r[k]) cl_r[k] <= cl3_r[k];
        if (ol2_r[k] == ol3_r[k]) ol_r[k] <= ol3_r[k];
      end
    end
  end

  swcs_brk_t brk;
  assign brk = brk_r;

  // Configuration registers
  logic [3:0] ctrl_r;
  logic [15:0] tdis_r, tsyn_r, trun_r, tslw_r;
  logic single;
  assign single = ctrl_r[SWCS_CTRL_SINGLE_BIT];

  // Position decode
  swcs_pos_t pos;
  always_comb begin
    pos.closed = brk.aux_on & ~brk.aux_off; // RULE_22 RULE_18
    pos.open = ~brk.aux_on & brk.aux_off; // RULE_22 RULE_19
    pos.indeterm = ~brk.aux_on & ~brk.aux_off & ~single; // RULE_22 RULE_21
    pos.contra = brk.aux_on & brk.aux_off & ~single; // RULE_22 RULE_21
    if (single) begin
      pos.closed = brk.aux_on;
      pos.open = ~brk.aux_on;
    end
  end

  // Millisecond tick
  logic [$clog2(SWCS_TICK_CYC)-1:0] pre_r;
  logic tick;
  assign tick = (pre_r == '0);
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) pre_r <= '0;
    else if (i_ce) pre_r <= tick ? ($clog2(SWCS_TICK_CYC))'(SWCS_TICK_CYC - 1) : pre_r - 1'b1;
  end

  // Disturbed-position supervision timer
  logic [15:0] dis_cnt_r;
  logic disturb_r;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dis_cnt_r <= '0;
      disturb_r <= 1'b0;
    end else if (i_ce) begin
      if (!pos.contra) begin
        dis_cnt_r <= '0;
        disturb_r <= 1'b0;
      end else if (dis_cnt_r >= tdis_r) begin
        disturb_r <= 1'b1; // RULE_02
      end else if (tick) begin
        dis_cnt_r <= dis_cnt_r + 16'h0001;
      end
    end
  end

  // Trip pending: set by protection trip, held until acknowledged
  logic trip_pend_r;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) trip_pend_r <= 1'b0;
    else if (i_ce) begin
      if (i_protection_open_request) trip_pend_r <= 1'b1;
      else if (i_trip_acknowledge) trip_pend_r <= 1'b0;
    end
  end

  // Command edge detection
  logic on_d_r, off_d_r;
  logic on_req, off_req;
  assign on_req = i_cmd_on & ~on_d_r;
  assign off_req = i_cmd_off & ~off_d_r;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      on_d_r <= 1'b0;
      off_d_r <= 1'b0;
    end else if (i_ce) begin
      on_d_r <= i_cmd_on;
      off_d_r <= i_cmd_off;
    end
  end

  // Command supervision state machine
  swcs_state_t state_r;
  logic dir_on_r;
  logic [15:0] run_cnt_r;
  logic man_on_r, man_off_r;
  logic [SWCS_NFLAG-1:0] flags_r;
  logic slow_r;
  logic [SWCS_NFLAG-1:0] rej;
  logic req, req_on, off_pend;
  assign req = on_req | off_req;
  assign req_on = on_req; // Close takes the request when both arrive together
  assign off_pend = (state_r == SWCS_RUN) & ~dir_on_r;

  // Rejection cause, highest priority first, one cause only
  always_comb begin
    rej = '0;
    if (on_req && off_pend) rej[SWCS_F_ONOFF] = 1'b1; // RULE_11
    else if (state_r != SWCS_IDLE) rej = '0;
    else if (trip_pend_r) rej[SWCS_F_TRIP] = 1'b1; // RULE_09
    else if (brk.removed) rej[SWCS_F_WDRN] = 1'b1; // RULE_15
    else if (!brk.ready) rej[SWCS_F_NRDY] = 1'b1; // RULE_12
    else if (req_on ? (|cl_r) : (|ol_r)) rej[SWCS_F_LOCK] = 1'b1; // RULE_13
    else if (req_on ? pos.closed : pos.open) rej[SWCS_F_DIR] = 1'b1; // RULE_10
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= SWCS_IDLE;
      dir_on_r <= 1'b0;
      run_cnt_r <= '0;
      man_on_r <= 1'b0;
      man_off_r <= 1'b0;
      flags_r <= '0;
      slow_r <= 1'b0;
    end else if (i_ce) begin
      if (req && (|rej)) begin
        flags_r <= rej; // RULE_23
      end
      if (tick && state_r != SWCS_IDLE) run_cnt_r <= run_cnt_r + 16'h0001;
      unique case (state_r)
        SWCS_IDLE: begin
          if (req && !(|rej)) begin
            flags_r <= '0; // RULE_23
            dir_on_r <= req_on;
            run_cnt_r <= '0;
            if (req_on && ctrl_r[SWCS_CTRL_SYNC_BIT]) begin
              state_r <= SWCS_SYNC;
            end else begin
              state_r <= SWCS_RUN;
              man_on_r <= req_on;
              man_off_r <= ~req_on;
            end
          end
        end
        SWCS_SYNC: begin
          if (brk.in_sync) begin // RULE_20
            state_r <= SWCS_RUN;
            man_on_r <= 1'b1;
            run_cnt_r <= '0;
          end else if (run_cnt_r >= tsyn_r) begin
            state_r <= SWCS_IDLE; // RULE_14
            flags_r[SWCS_F_SYNC] <= 1'b1; // RULE_14
          end
        end
        SWCS_RUN: begin
          if (dir_on_r ? pos.closed : pos.open) begin
            state_r <= SWCS_IDLE;
            man_on_r <= 1'b0;
            man_off_r <= 1'b0;
            flags_r <= SWCS_NFLAG'(1 << SWCS_F_OK); // RULE_07 RULE_23
            if (run_cnt_r > tslw_r) slow_r <= 1'b1; // RULE_17
          end else if (run_cnt_r >= trun_r) begin
            state_r <= SWCS_IDLE;
            man_on_r <= 1'b0;
            man_off_r <= 1'b0;
            // Outcome replaces any earlier flag so only one cause stands
            if (disturb_r) flags_r <= SWCS_NFLAG'(1 << SWCS_F_DIST); // RULE_08
            else flags_r <= SWCS_NFLAG'(1 << SWCS_F_RUN);
          end
        end
      endcase
      if (i_slow_breaker_alarm_clear && !(state_r == SWCS_RUN && (dir_on_r ? pos.closed : pos.open)
          && run_cnt_r > tslw_r)) begin
        slow_r <= 1'b0; // RULE_17
      end
    end
  end

  // Outputs to breaker and status, all registered
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_on_cmd <= 1'b0;
      o_off_cmd <= 1'b0;
      o_sync_on_request <= 1'b0;
      o_pos_on <= 1'b0;
      o_pos_off <= 1'b0;
      o_pos_indeterm <= 1'b0;
      o_pos_disturb <= 1'b0;
      o_ready <= 1'b0;
      o_removed <= 1'b0;
      o_close_lock <= 1'b0;
      o_open_lock <= 1'b0;
      o_trip_pending <= 1'b0;
      o_slow_breaker_alarm <= 1'b0;
      o_flags <= '0;
    end else if (i_ce) begin
      o_on_cmd <= man_on_r | (i_prot_on & ctrl_r[SWCS_CTRL_INCL_ON_BIT]); // RULE_16
      o_off_cmd <= man_off_r | (trip_pend_r & ctrl_r[SWCS_CTRL_INCL_OFF_BIT]); // RULE_16
      o_sync_on_request <= (state_r == SWCS_SYNC);
      o_pos_on <= pos.closed;
      o_pos_off <= pos.open;
      o_pos_indeterm <= pos.indeterm | (pos.contra & ~disturb_r); // RULE_01
      o_pos_disturb <= disturb_r; // RULE_02
      o_ready <= brk.ready; // RULE_03
      o_removed <= brk.removed; // RULE_04
      o_close_lock <= |cl_r; // RULE_05
      o_open_lock <= |ol_r; // RULE_06
      o_trip_pending <= trip_pend_r;
      o_slow_breaker_alarm <= slow_r;
      o_flags <= flags_r;
    end
  end

  // Register writes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= SWCS_CTRL_RST;
      tdis_r <= SWCS_TDIS_RST;
      tsyn_r <= SWCS_TSYN_RST;
      trun_r <= SWCS_TRUN_RST;
      tslw_r <= SWCS_TSLW_RST;
    end else if (i_ce && i_wr) begin
      unique case (i_addr)
        SWCS_CTRL_OFS: ctrl_r <= i_wdata[3:0];
        SWCS_TDIS_OFS: tdis_r <= i_wdata[15:0];
        SWCS_TSYN_OFS: tsyn_r <= i_wdata[15:0];
        SWCS_TRUN_OFS: trun_r <= i_wdata[15:0];
        SWCS_TSLW_OFS: tslw_r <= i_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Register reads, data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) o_rdata <= '0;
    else if (i_ce) begin
      o_rdata <= '0;
      if (i_rd) begin
        unique case (i_addr)
          SWCS_CTRL_OFS: o_rdata <= {28'h0, ctrl_r};
          SWCS_STAT_OFS: o_rdata <= {21'h0, state_r, 2'h0, slow_r, trip_pend_r, disturb_r, pos};
          SWCS_FLAG_OFS: o_rdata <= {22'h0, flags_r};
          SWCS_TDIS_OFS: o_rdata <= {16'h0, tdis_r};
          SWCS_TSYN_OFS: o_rdata <= {16'h0, tsyn_r};
          SWCS_TRUN_OFS: o_rdata <= {16'h0, trun_r};
          SWCS_TSLW_OFS: o_rdata <= {16'h0, tslw_r};
          default: o_rdata <= '0;
        endcase
      end
    end
  end

endmodule

// ===== swcs_breaker_model.sv
// Behavioural breaker: auxiliary contacts, ready, removed and synchroniser
`timescale 1ns/1ps
module swcs_breaker_model
  import swcs_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Commands from the block
  input wire logic i_on,
  input wire logic i_off,
  input wire logic i_sync_req,
  // Scenario controls
  input wire logic i_ready,
  input wire logic i_removed,
  input wire logic i_fault,
  input wire logic i_sync_ok,
  input wire logic [7:0] i_travel,
  // Breaker pins
  output swcs_brk_t o_brk
);
  logic closed_r;
  logic [7:0] cnt_r;
  logic [1:0] sync_r;
  // Travel counter; contacts read open-open while moving
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      closed_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'h01) begin
      closed_r <= !closed_r;
      cnt_r <= 8'h00;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end else if ((i_on && !closed_r) || (i_off && closed_r)) begin
      cnt_r <= i_travel;
    end
  end
  // In-sync answer two cycles after a synchronous close request
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_r <= 2'h0;
    end else begin
      sync_r <= {sync_r[0], i_sync_req & i_sync_ok};
    end
  end
  // Pins; a fault forces both contacts active
  assign o_brk.aux_on = i_fault | (closed_r && cnt_r == 8'h00);
  assign o_brk.aux_off = i_fault | (!closed_r && cnt_r == 8'h00);
  assign o_brk.ready = i_ready;
  assign o_brk.removed = i_removed;
  assign o_brk.in_sync = sync_r[1];
endmodule

// ===== swcs_monitor.sv
// Port checker for the switchgear unit
`timescale 1ns/1ps
module swcs_monitor
  import swcs_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Watched inputs
  input wire swcs_brk_t i_brk,
  input wire logic [2:0] i_close_lock_input,
  input wire logic [2:0] i_open_lock_input,
  input wire logic i_cmd_off,
  // Watched outputs
  input wire logic o_on_cmd,
  input wire logic o_off_cmd,
  input wire logic o_sync_on_request,
  input wire logic o_pos_on,
  input wire logic o_pos_off,
  input wire logic o_pos_disturb,
  input wire logic o_ready,
  input wire logic o_removed,
  input wire logic o_close_lock,
  input wire logic o_open_lock,
  input wire logic o_trip_pending,
  input wire logic [SWCS_NFLAG-1:0] o_flags
);
  logic idle;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // No command running and no trip pending
  assign idle = !o_on_cmd && !o_off_cmd && !o_sync_on_request && !o_trip_pending;
  property p_close_lock; ($stable(i_close_lock_input) && i_ce)[*8] |-> o_close_lock == |i_close_lock_input;
  endproperty
  a_close_lock: assert property (p_close_lock) else $error("close lock wrong");
  property p_open_lock; ($stable(i_open_lock_input) && i_ce)[*8] |-> o_open_lock == |i_open_lock_input;
  endproperty
  a_open_lock: assert property (p_open_lock) else $error("open lock wrong");
  property p_ready; ($stable(i_brk.ready) && i_ce)[*8] |-> o_ready == i_brk.ready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_removed; ($stable(i_brk.removed) && i_ce)[*8] |-> o_removed == i_brk.removed;
  endproperty
  a_removed: assert property (p_removed) else $error("removed wrong");
  property p_pos; ($stable({i_brk.aux_on, i_brk.aux_off}) && i_ce)[*8]
    |-> {o_pos_on, o_pos_off} == {i_brk.aux_on & !i_brk.aux_off, !i_brk.aux_on & i_brk.aux_off};
  endproperty
  a_pos: assert property (p_pos) else $error("position decode wrong");
  property p_disturb; $rose(o_pos_disturb) |-> $past(i_brk.aux_on && i_brk.aux_off, 6);
  endproperty
  a_disturb: assert property (p_disturb) else $error("disturbed without contradiction");
  property p_one_cause; $onehot0(o_flags);
  endproperty
  a_one_cause: assert property (p_one_cause) else $error("several flags");
  property p_withdrawn; $rose(i_cmd_off) && idle && o_removed |-> ##[1:3] o_flags == SWCS_NFLAG'(1 << SWCS_F_WDRN);
  endproperty
  a_withdrawn: assert property (p_withdrawn) else $error("withdrawn flag missing");
  property p_not_ready; $rose(i_cmd_off) && idle && !o_removed && !o_ready
    |-> ##[1:3] o_flags == SWCS_NFLAG'(1 << SWCS_F_NRDY);
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("not ready flag missing");
  property p_trip_off; o_trip_pending[*3] |-> o_off_cmd;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("trip not in open command");
  // Main scenarios reached
  c_success: cover property (o_flags[SWCS_F_OK]);
  c_sync: cover property (o_flags[SWCS_F_SYNC]);
  c_disturb: cover property ($rose(o_pos_disturb));
endmodule
bind swcs_switchgear_unit swcs_monitor u_mon (.i_ref_clk, .i_rst, .i_ce, .i_brk, .i_close_lock_input,
  .i_open_lock_input, .i_cmd_off, .o_on_cmd, .o_off_cmd, .o_sync_on_request, .o_pos_on, .o_pos_off,
  .o_pos_disturb, .o_ready, .o_removed, .o_close_lock, .o_open_lock, .o_trip_pending, .o_flags);

// ===== swcs_switchgear_unit_tb_top.sv
// Testbench for the switchgear unit
`timescale 1ns/1ps
module swcs_switchgear_unit_tb_top;
  import swcs_pkg::*;
  // Stimulus and breaker controls
  logic i_ref_clk, i_rst, i_ce, i_wr, i_rd, i_cmd_on, i_cmd_off, i_prot_on;
  logic i_protection_open_request, i_trip_acknowledge, i_slow_breaker_alarm_clear, rdy, rem, flt, sok;
  logic [7:0] i_addr, trav;
  logic [31:0] i_wdata, o_rdata;
  logic [2:0] i_close_lock_input, i_open_lock_input;
  // Observed outputs
  swcs_brk_t i_brk;
  logic [SWCS_NFLAG-1:0] o_flags;
  logic o_on_cmd, o_off_cmd, o_sync_on_request, o_pos_on, o_pos_off, o_pos_indeterm, o_pos_disturb;
  logic o_ready, o_removed, o_close_lock, o_open_lock, o_trip_pending, o_slow_breaker_alarm;
  int failures, n_checks;
  swcs_switchgear_unit dut (.i_ref_clk, .i_rst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_brk,
    .i_close_lock_input, .i_open_lock_input, .i_cmd_on, .i_cmd_off, .i_prot_on, .i_protection_open_request,
    .i_trip_acknowledge, .i_slow_breaker_alarm_clear, .o_on_cmd, .o_off_cmd, .o_sync_on_request, .o_pos_on,
    .o_pos_off, .o_pos_indeterm, .o_pos_disturb, .o_ready, .o_removed, .o_close_lock, .o_open_lock,
    .o_trip_pending, .o_slow_breaker_alarm, .o_flags);
  swcs_breaker_model brk (.i_ref_clk, .i_rst, .i_on(o_on_cmd), .i_off(o_off_cmd), .i_sync_req(o_sync_on_request),
    .i_ready(rdy), .i_removed(rem), .i_fault(flt), .i_sync_ok(sok), .i_travel(trav), .o_brk(i_brk));
  // Clock of 40 ns
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
    @(posedge i_ref_clk);
  endtask
  // Pulse a command and wait for the single expected flag
  task automatic req(input logic on, input logic off, input int bit_no, input int lim);
    i_cmd_on <= on;
    i_cmd_off <= off;
    @(posedge i_ref_clk);
    i_cmd_on <= 1'b0;
    i_cmd_off <= 1'b0;
    for (int k = 0; k < lim; k++) begin
      @(posedge i_ref_clk);
      if (o_flags === SWCS_NFLAG'(1 << bit_no)) break;
    end
    chk(o_flags, 32'h1 << bit_no);
  endtask
  // Reset values, unmapped read, short timers
  task automatic t_regs();
    rd(SWCS_CTRL_OFS, 32'(SWCS_CTRL_RST));
    rd(SWCS_TDIS_OFS, 32'(SWCS_TDIS_RST));
    rd(SWCS_TSYN_OFS, 32'(SWCS_TSYN_RST));
    rd(SWCS_TRUN_OFS, 32'(SWCS_TRUN_RST));
    rd(SWCS_TSLW_OFS, 32'(SWCS_TSLW_RST));
    rd(8'h1c, 32'h0);
    wr(SWCS_TDIS_OFS, 32'h1);
    wr(SWCS_TSYN_OFS, 32'h1);
    rd(SWCS_TSYN_OFS, 32'h1);
  endtask
  // Interlock OR for each input, ready and removed
  task automatic t_pins();
    for (int i = 0; i < 3; i++) begin
      i_close_lock_input <= 3'h1 << i;
      i_open_lock_input <= 3'h4 >> i;
      settle();
      chk({o_close_lock, o_open_lock}, 2'b11);
    end
    i_close_lock_input <= 3'h0;
    i_open_lock_input <= 3'h0;
    rdy <= 1'b0;
    rem <= 1'b1;
    settle();
    chk({o_close_lock, o_open_lock, o_ready, o_removed}, 4'b0001);
    rdy <= 1'b1;
    rem <= 1'b0;
    settle();
  endtask
  // Direction check and a good close
  task automatic t_position();
    req(1'b0, 1'b1, SWCS_F_DIR, 20);
    req(1'b1, 1'b0, SWCS_F_OK, 100);
    chk(o_pos_on, 1'b1);
    req(1'b1, 1'b0, SWCS_F_DIR, 20);
  endtask
  // Refusals on a closed breaker
  task automatic t_refusals();
    i_open_lock_input <= 3'h2;
    settle();
    req(1'b0, 1'b1, SWCS_F_LOCK, 20);
    i_open_lock_input <= 3'h0;
    rdy <= 1'b0;
    settle();
    req(1'b0, 1'b1, SWCS_F_NRDY, 20);
    rdy <= 1'b1;
    rem <= 1'b1;
    settle();
    req(1'b0, 1'b1, SWCS_F_WDRN, 20);
    rem <= 1'b0;
    settle();
    i_prot_on <= 1'b1;
    settle();
    chk(o_on_cmd, 1'b1);
    wr(SWCS_CTRL_OFS, 32'h4);
    settle();
    chk(o_on_cmd, 1'b0);
    i_prot_on <= 1'b0;
    wr(SWCS_CTRL_OFS, 32'h6);
  endtask
  // Close arriving while a slow open runs
  task automatic t_close_during_open();
    trav <= 8'd100;
    i_cmd_off <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    chk(o_flags, 32'h0);
    req(1'b1, 1'b0, SWCS_F_ONOFF, 20);
    req(1'b0, 1'b0, SWCS_F_OK, 150);
    trav <= 8'd10;
  endtask
  // Pending trip drives open and refuses commands
  task automatic t_trip();
    i_protection_open_request <= 1'b1;
    settle();
    chk({o_trip_pending, o_off_cmd}, 2'b11);
    req(1'b1, 1'b0, SWCS_F_TRIP, 20);
    i_protection_open_request <= 1'b0;
    i_trip_acknowledge <= 1'b1;
    settle();
    i_trip_acknowledge <= 1'b0;
    settle();
    chk(o_trip_pending, 1'b0);
  endtask
  // Synchronised close: timeout on contradicting contacts, then success
  task automatic t_sync();
    wr(SWCS_CTRL_OFS, 32'he);
    sok <= 1'b0;
    flt <= 1'b1;
    settle();
    chk(o_pos_indeterm, 1'b1);
    req(1'b1, 1'b0, SWCS_F_SYNC, 60000);
    chk(o_pos_disturb, 1'b1);
    flt <= 1'b0;
    sok <= 1'b1;
    settle();
    req(1'b1, 1'b0, SWCS_F_OK, 200);
  endtask
  // Run timeout while disturbed, then a close spanning a tick and the alarm clear
  task automatic t_slow();
    wr(SWCS_TDIS_OFS, 32'h0);
    wr(SWCS_TRUN_OFS, 32'h1);
    wr(SWCS_TSLW_OFS, 32'h0);
    flt <= 1'b1;
    req(1'b0, 1'b1, SWCS_F_DIST, 30000);
    wr(SWCS_TRUN_OFS, 32'(SWCS_TRUN_RST));
    i_cmd_on <= 1'b1;
    repeat (25100) @(posedge i_ref_clk);
    chk(o_flags, 32'h0);
    flt <= 1'b0;
    req(1'b0, 1'b0, SWCS_F_OK, 20);
    chk(o_slow_breaker_alarm, 1'b1);
    i_slow_breaker_alarm_clear <= 1'b1;
    settle();
    chk(o_slow_breaker_alarm, 1'b0);
    i_slow_breaker_alarm_clear <= 1'b0;
  endtask
  task automatic final_report();
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog: the run needs about three 1 ms ticks
  initial begin
    #(90000 * 40);
    failures++;
    final_report();
  end
  // Main sequence
  initial begin
    {i_wr, i_rd, i_cmd_on, i_cmd_off, i_prot_on, i_protection_open_request} = 6'h0;
    {i_trip_acknowledge, i_slow_breaker_alarm_clear, rem, flt, sok} = 5'h0;
    {i_addr, i_wdata, i_close_lock_input, i_open_lock_input} = 46'h0;
    {i_rst, i_ce, rdy} = 3'b111;
    trav = 8'd10;
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    settle();
    t_regs();
    t_pins();
    t_position();
    t_refusals();
    t_close_during_open();
    t_trip();
    t_sync();
    t_slow();
    final_report();
  end
endmodule
